// file: rtl/sspm_master.sv
// SPI master for a secure element, with Avalon-MM control registers
// What this block does
// - Full-duplex: every byte sent on master-out also captures a byte from master-in.
// - One select line per slave; this master drives exactly one slave.
// - Select is asserted low, idle high.
// - Five-wire variant: slave request counts at the request line's rising edge.
// - Four-wire select is open drain: drive low or release only.
// - Shared select idles high by pull-up, low when either side asserts.
// - Internal select-assert output is active high and pulls the line low.
// - Internal select-sense reads high when idle, low when asserted.
// - Clock and data lines are shareable; only select is per slave.
// - Transfers use clock mode 0.
// - Serial clock is held low whenever no transfer runs.
// - Incoming data sampled on rising serial clock edges.
// - Slave requests are detected on edges, not levels.
module sspm_master (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic spi_sclk,
    output logic spi_mosi,
    input wire logic spi_miso,
    input wire logic slave_select_n_in,
    output logic slave_select_n_out,
    output logic slave_select_n_oe,
    input wire logic slave_request,
    output logic master_select_assert_out
);
    import sspm_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOW,
        ST_HIGH,
        ST_LAST
    } sspm_phase_t;

    typedef struct packed {
        sspm_phase_t phase;
        logic four_wire;
        logic sel_hold;
        logic [7:0] div;
        logic [7:0] div_cnt;
        logic [7:0] tx_shift;
        logic [7:0] rx_shift;
        logic [7:0] rx_data;
        logic [2:0] bit_cnt;
        logic req_flag;
        logic sense_prev;
        logic request_prev;
        logic sel_assert;
        logic sclk;
        logic mosi;
        logic ack;
        logic [31:0] rdata;
    } sspm_state_t;

    sspm_state_t s_reg;
    sspm_state_t s_next;
    sspm_pins_in_t pins_sync;
    logic master_select_sense_in;
    logic tick;
    logic busy;
    logic sense_fall;
    logic request_rise;

    sspm_sync #(
        .WIDTH(3)
    ) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .async_in({spi_miso, slave_select_n_in, slave_request}),
        .sync_out(pins_sync)
    );

    // Sense is high while the line is idle, low while asserted
    assign master_select_sense_in = pins_sync.slave_select_n;
    assign busy = (s_reg.phase != ST_IDLE);
    assign tick = (s_reg.div_cnt == 8'h00);
    // Edge detection keeps a held request from firing again
    assign request_rise = pins_sync.request && !s_reg.request_prev;
    // In four-wire mode, a falling sense that we did not cause is a slave request
    assign sense_fall = s_reg.four_wire && s_reg.sense_prev
        && !master_select_sense_in && !s_reg.sel_assert;

    function automatic logic [31:0] read_word(input logic [3:0] addr, input sspm_state_t st,
                                              input logic bsy, input logic sense);
        logic [31:0] w;
        w = UNMAPPED_DATA;
        case (addr)
            ADDR_CTRL: begin
                w[CTRL_FOUR_WIRE] = st.four_wire;
                w[CTRL_SEL_HOLD] = st.sel_hold;
            end
            ADDR_DIV: w[7:0] = st.div;
            ADDR_TXD: w[7:0] = st.tx_shift;
            ADDR_STAT: begin
                w[STAT_BUSY] = bsy;
                w[STAT_REQ] = st.req_flag;
                w[STAT_SENSE] = sense;
                w[STAT_RXD_LSB +: 8] = st.rx_data;
            end
            default: w = UNMAPPED_DATA;
        endcase
        return w;
    endfunction

    always_comb begin
        s_next = s_reg;
        s_next.ack = 1'b0;
        s_next.sense_prev = master_select_sense_in;
        s_next.request_prev = pins_sync.request;
        s_next.div_cnt = tick ? s_reg.div : s_reg.div_cnt - 8'h01;

        // Bus access: one wait cycle, answered on the second edge
        if ((avs_read || avs_write) && !s_reg.ack) begin
            s_next.ack = 1'b1;
            s_next.rdata = read_word(avs_address, s_reg, busy, master_select_sense_in);
            if (avs_write) begin
                case (avs_address)
                    ADDR_CTRL: begin
                        s_next.four_wire = avs_writedata[CTRL_FOUR_WIRE];
                        s_next.sel_hold = avs_writedata[CTRL_SEL_HOLD];
                    end
                    // Software loads the slave's reported maximum here
                    ADDR_DIV: s_next.div = (avs_writedata[7:0] < DIV_MIN) ? DIV_MIN
                        : avs_writedata[7:0];
                    ADDR_TXD: begin
                        if (!busy) begin
                            s_next.tx_shift = avs_writedata[7:0];
                            s_next.mosi = avs_writedata[7];
                            s_next.bit_cnt = 3'h7;
                            s_next.phase = ST_LOW;
                            s_next.div_cnt = s_reg.div;
                            s_next.sel_assert = 1'b1;
                        end
                    end
                    default: s_next.rdata = UNMAPPED_DATA;
                endcase
            end
        end

        case (s_reg.phase)
            ST_IDLE: begin
                s_next.sclk = 1'b0;
                // Keep a select that a new byte has just raised or the hold bit holds; release it otherwise
                if (s_next.phase == ST_IDLE && !s_next.sel_hold) begin
                    s_next.sel_assert = 1'b0;
                end
            end
            ST_LOW: begin
                if (tick) begin
                    s_next.sclk = 1'b1;
                    // Sample master-in on the rising edge
                    s_next.rx_shift = {s_reg.rx_shift[6:0], pins_sync.miso};
                    s_next.phase = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (tick) begin
                    s_next.sclk = 1'b0;
                    if (s_reg.bit_cnt == 3'h0) begin
                        s_next.phase = ST_LAST;
                        s_next.rx_data = s_reg.rx_shift;
                    end else begin
                        // New bit after the falling edge, MSB first
                        s_next.tx_shift = {s_reg.tx_shift[6:0], 1'b0};
                        s_next.mosi = s_reg.tx_shift[6];
                        s_next.bit_cnt = s_reg.bit_cnt - 3'h1;
                        s_next.phase = ST_LOW;
                    end
                end
            end
            ST_LAST: begin
                // Half a clock of select hold after the last falling edge
                if (tick) begin
                    s_next.phase = ST_IDLE;
                    s_next.sel_assert = s_reg.sel_hold;
                end
            end
            default: s_next.phase = ST_IDLE;
        endcase

        // Set wins over a clear in the same cycle
        if (avs_write && !s_reg.ack && avs_address == ADDR_CTRL
                && avs_writedata[CTRL_REQ_CLR]) begin
            s_next.req_flag = 1'b0;
        end
        if (request_rise || sense_fall) begin
            s_next.req_flag = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
            s_reg.div <= DIV_RESET;
            s_reg.sense_prev <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !s_reg.ack;
    assign avs_readdata = s_reg.rdata;
    // Clock and data carry nothing per slave, so they may fan out to a shared bus
    assign spi_sclk = s_reg.sclk;
    assign spi_mosi = s_reg.mosi;
    // Active-high assert output
    assign master_select_assert_out = s_reg.sel_assert;
    // Open drain: only ever drive low, release otherwise
    assign slave_select_n_out = 1'b0;
    // A single select output: this master addresses exactly one slave
    assign slave_select_n_oe = s_reg.sel_assert;

    property p_sclk_idle_low;
        @(posedge core_clk) disable iff (!nrst)
        (s_reg.phase == ST_IDLE) |-> !spi_sclk;
    endproperty
    a_sclk_idle_low: assert property (p_sclk_idle_low)
        else $error("Serial clock high while idle");

    property p_mosi_stable_high;
        @(posedge core_clk) disable iff (!nrst)
        (spi_sclk && $past(spi_sclk)) |-> $stable(spi_mosi);
    endproperty
    a_mosi_stable_high: assert property (p_mosi_stable_high)
        else $error("Master-out changed while clock high");

    property p_mosi_on_fall;
        @(posedge core_clk) disable iff (!nrst)
        ($changed(spi_mosi) && busy && $past(busy)) |-> $fell(spi_sclk);
    endproperty
    a_mosi_on_fall: assert property (p_mosi_on_fall)
        else $error("Master-out changed away from a falling edge");

    property p_sel_during_clock;
        @(posedge core_clk) disable iff (!nrst)
        spi_sclk |-> (slave_select_n_oe && master_select_assert_out);
    endproperty
    a_sel_during_clock: assert property (p_sel_during_clock)
        else $error("Clock ran without select asserted");

    property p_od_low_only;
        @(posedge core_clk) disable iff (!nrst)
        slave_select_n_oe |-> !slave_select_n_out;
    endproperty
    a_od_low_only: assert property (p_od_low_only)
        else $error("Select driven high");

    property p_req_edge;
        @(posedge core_clk) disable iff (!nrst)
        (pins_sync.request && !s_reg.request_prev) |=> s_reg.req_flag;
    endproperty
    a_req_edge: assert property (p_req_edge)
        else $error("Request edge not latched");

    property p_sense_req;
        @(posedge core_clk) disable iff (!nrst)
        (s_reg.four_wire && s_reg.sense_prev && !master_select_sense_in
            && !s_reg.sel_assert) |=> s_reg.req_flag;
    endproperty
    a_sense_req: assert property (p_sense_req)
        else $error("Select pulled by slave not latched");

    property p_msb_first;
        @(posedge core_clk) disable iff (!nrst)
        ($past(s_reg.phase) == ST_IDLE && s_reg.phase == ST_LOW) |-> spi_mosi == s_reg.tx_shift[7];
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("First bit is not the MSB");

    property p_wait_one;
        @(posedge core_clk) disable iff (!nrst)
        ((avs_read || avs_write) && !s_reg.ack) |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("Bus answer later than one wait cycle");

    // Select may only drop once the byte and its tail are over
    property p_sel_drop_idle;
        @(posedge core_clk) disable iff (!nrst)
        $fell(master_select_assert_out) |-> (s_reg.phase == ST_IDLE);
    endproperty
    a_sel_drop_idle: assert property (p_sel_drop_idle)
        else $error("Select released in mid-byte");

    // A clear with no new edge must leave the flag low, even if the line stays active
    property p_req_clear;
        @(posedge core_clk) disable iff (!nrst)
        (avs_write && !s_reg.ack && avs_address == ADDR_CTRL && avs_writedata[CTRL_REQ_CLR]
            && !request_rise && !sense_fall) |=> !s_reg.req_flag;
    endproperty
    a_req_clear: assert property (p_req_clear)
        else $error("Request flag survived a clear");
endmodule

// file: rtl/sspm_pkg.sv
// Package: constants and carrier types for the secure-element SPI master
package sspm_pkg;

    localparam int CLK_HZ = 25000000;
    // Minimum slave request pulse, in ns
    localparam int SLAVE_REQ_PULSE_NS = 1000;
    localparam int SLAVE_REQ_PULSE_CYC = (SLAVE_REQ_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;

    // Register byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_DIV = 4'h4;
    localparam logic [3:0] ADDR_TXD = 4'h8;
    localparam logic [3:0] ADDR_STAT = 4'hc;

    // Control register fields
    localparam int CTRL_FOUR_WIRE = 0;
    localparam int CTRL_SEL_HOLD = 1;
    localparam int CTRL_REQ_CLR = 2;
    // Status register fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_REQ = 1;
    localparam int STAT_SENSE = 2;
    localparam int STAT_RXD_LSB = 8;

    localparam logic [7:0] DIV_RESET = 8'h04;
    localparam logic [7:0] DIV_MIN = 8'h01;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0;

    typedef struct packed {
        logic sclk;
        logic mosi;
        logic sel_assert;
    } sspm_pins_out_t;

    typedef struct packed {
        logic miso;
        logic slave_select_n;
        logic request;
    } sspm_pins_in_t;

endpackage

// file: rtl/sspm_sync.sv
// Two flip-flop synchroniser for a bundle of pin levels
module sspm_sync #(
    parameter int WIDTH = 3
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sspm_sync_state_t;

    sspm_sync_state_t state_reg;
    sspm_sync_state_t state_next;

    always_comb begin
        state_next.meta = async_in;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stable;
endmodule

// file: verif/sspm_slave_model.sv
// Behavioural secure-element slave that faces the SPI master
module sspm_slave_model #(
    parameter int REQ_NS = 1000,
    parameter int MAX_SCLK_HZ = 5000000 // Reported top rate; bench dividers stay below it
) (
    input wire logic sclk,
    input wire logic mosi,
    input wire logic sel_n,
    input wire logic kick,
    input wire logic four_wire,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic sel_assert,
    output logic request,
    output logic [7:0] rx_byte,
    output int nbytes
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh;
    logic [7:0] rx;
    int bitn;
    initial begin
        miso = 1'b0;
        sel_assert = 1'b0;
        request = 1'b0;
        rx_byte = 8'h00;
        nbytes = 0;
        bitn = 0;
    end
    // Own pull of the select is a request, not a selection
    always @(negedge sel_n) begin
        if (!sel_assert) begin
            sh = tx_byte;
            miso = sh[7];
            bitn = 0;
        end
    end
    // Sample master-out on rising clock only while selected
    always @(posedge sclk) begin
        if (!sel_n) begin
            rx = {rx[6:0], mosi};
            bitn++;
            if (bitn == 8) begin
                rx_byte = rx;
                nbytes++;
                bitn = 0;
            end
        end
    end
    // Next bit goes out after the falling edge
    always @(negedge sclk) begin
        if (!sel_n) begin
            sh = {sh[6:0], 1'b0};
            miso = sh[7];
        end
    end
    // Released line has no keeper, so show the inverse rather than a stale bit
    always @(posedge sel_n) miso = ~miso;
    // Unprompted request pulse of the minimum width
    always @(posedge kick) begin
        if (four_wire) sel_assert = 1'b1;
        else request = 1'b1;
        #(REQ_NS);
        sel_assert = 1'b0;
        request = 1'b0;
    end
endmodule

// file: verif/tb_sspm_master.sv
// Self-checking bench for the secure-element SPI master
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_sspm_master;
    timeunit 1ns;
    timeprecision 1ps;
    import sspm_pkg::*;
    typedef struct {int div; logic [7:0] tx; logic [7:0] sb;} sspm_row_t;
    sspm_row_t rows[3] = '{'{2, 8'ha5, 8'h5a}, '{3, 8'h3c, 8'hc3}, '{7, 8'h81, 8'h7e}};
    logic core_clk, nrst, avs_read, avs_write, avs_waitrequest, kick, four_wire;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic spi_sclk, spi_mosi, spi_miso, sel_n, sel_n_out, sel_n_oe, slv_assert;
    logic slave_request, sel_assert_out;
    logic [7:0] s_tx, s_rx;
    int nbytes, err_count, comparisons, hi_cnt;
    // Open drain with pull-up: low when either side pulls
    assign sel_n = (sel_n_oe ? sel_n_out : 1'b1) & !slv_assert;
    sspm_master sspm_master_i (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .slave_select_n_in(sel_n),
        .slave_select_n_out(sel_n_out), .slave_select_n_oe(sel_n_oe),
        .slave_request(slave_request), .master_select_assert_out(sel_assert_out));
    sspm_slave_model sspm_slave_model_i (.sclk(spi_sclk), .mosi(spi_mosi), .sel_n(sel_n),
        .kick(kick), .four_wire(four_wire), .tx_byte(s_tx), .miso(spi_miso),
        .sel_assert(slv_assert), .request(slave_request), .rx_byte(s_rx), .nbytes(nbytes));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        if (nrst) begin
            if (spi_sclk) hi_cnt++;
            if (spi_sclk) `CHK(sel_n_oe, 1'b1)
            `CHK(sel_assert_out, sel_n_oe)
            `CHK(sel_n_out, 1'b0)
        end
    end
    // Bus cycle: hold until waitrequest is seen low, then release
    task automatic av(input bit wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        begin
            n = 0;
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= wr;
            avs_read <= !wr;
            @(posedge core_clk);
            while (avs_waitrequest !== 1'b0 && n < 100) begin
                n++;
                @(posedge core_clk);
            end
            if (n >= 100) err_count++;
            r = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    task automatic xfer(input logic [7:0] div, input logic [7:0] tx, input logic [7:0] sb,
                        input bit dbl);
        int n0;
        begin
            n0 = nbytes;
            s_tx <= sb;
            av(1, ADDR_DIV, {24'h0, div}, q);
            hi_cnt = 0;
            av(1, ADDR_TXD, {24'h0, tx}, q);
            // A second byte while busy must be dropped
            if (dbl) av(1, ADDR_TXD, 32'h0000_00ff, q);
            q = 32'h1;
            for (int k = 0; k < 400 && q[STAT_BUSY] !== 1'b0; k++) av(0, ADDR_STAT, 0, q);
            `CHK(q[STAT_BUSY], 1'b0)
            if (dbl) repeat (200) @(posedge core_clk);
            `CHK(q[15:8], sb)
            `CHK(s_rx, tx)
            `CHK(nbytes - n0, 1)
            `CHK(hi_cnt, 8 * (div + 1))
        end
    endtask
    task report_and_stop;
        begin
            $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
            if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        #3000000;
        err_count++;
        report_and_stop;
    end
    initial begin
        nrst = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        kick = 1'b0;
        four_wire = 1'b0;
        s_tx = 8'h00;
        err_count = 0;
        comparisons = 0;
        hi_cnt = 0;
        repeat (16) @(posedge core_clk);
        `CHK({spi_sclk, sel_n_oe, sel_assert_out}, 3'b000)
        nrst <= 1'b1;
        @(posedge core_clk);
        av(0, ADDR_DIV, 0, q);
        `CHK(q[7:0], DIV_RESET)
        av(0, ADDR_STAT, 0, q);
        `CHK(q[2:0], 3'b100)
        av(1, 4'h2, 32'hff, q);
        av(0, 4'h2, 0, q);
        `CHK(q, UNMAPPED_DATA)
        foreach (rows[i]) xfer(rows[i].div[7:0], rows[i].tx, rows[i].sb, 1'b0);
        xfer(8'h02, 8'h11, 8'hee, 1'b1);
        // Held select survives the byte and drops with the hold bit
        av(1, ADDR_CTRL, 32'h2, q);
        av(0, ADDR_CTRL, 0, q);
        `CHK(q[1:0], 2'b10)
        xfer(8'h02, 8'h96, 8'h69, 1'b0);
        `CHK(sel_n_oe, 1'b1)
        av(1, ADDR_CTRL, 32'h0, q);
        `CHK(sel_n_oe, 1'b0)
        // Five-wire then four-wire request; clearing while the line is still active
        for (int m = 0; m < 2; m++) begin
            four_wire <= m[0];
            av(1, ADDR_CTRL, {31'h0, m[0]}, q);
            kick <= 1'b1;
            @(posedge core_clk);
            kick <= 1'b0;
            repeat (8) @(posedge core_clk);
            av(0, ADDR_STAT, 0, q);
            `CHK(q[2:1], {~m[0], 1'b1})
            av(1, ADDR_CTRL, {29'h0, 1'b1, 1'b0, m[0]}, q);
            av(0, ADDR_STAT, 0, q);
            `CHK(q[1], 1'b0)
            repeat (30) @(posedge core_clk);
            av(0, ADDR_STAT, 0, q);
            `CHK(q[2:1], 2'b10)
        end
        // Reset in mid-byte: link drops at once, registers return to reset values
        av(1, ADDR_TXD, 32'h5a, q);
        repeat (10) @(posedge core_clk);
        nrst <= 1'b0;
        @(posedge core_clk);
        `CHK({spi_sclk, spi_mosi, sel_n_oe, sel_assert_out}, 4'h0)
        nrst <= 1'b1;
        @(posedge core_clk);
        av(0, ADDR_DIV, 0, q);
        `CHK(q[7:0], DIV_RESET)
        av(0, ADDR_STAT, 0, q);
        `CHK(q[2:0], 3'b100)
        xfer(8'h02, 8'h00, 8'hff, 1'b0);
        report_and_stop;
    end
endmodule
